// >>> inc/ebp_pkg.sv
// ebp_pkg: constants and types for the external bus pin control block
package ebp_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int EBP_ADDR_W = 20;
  localparam int EBP_LOW_W = 16;
  localparam int EBP_DATA_W = 16;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic EBP_KEEP_RST = 1'b0;
  localparam logic [19:0] EBP_ADDR_RST = 20'h00000;
  localparam logic [15:0] EBP_DATA_RST = 16'h0000;
  localparam logic [2:0] EBP_CTL_RST = 3'h6;
  // ----------------------------------------
  // control synchroniser fields
  // ----------------------------------------
  localparam int EBP_CTL_RSTN_BIT = 2;
  localparam int EBP_CTL_FLOATN_BIT = 1;
  localparam int EBP_CTL_HOLD_BIT = 0;
  // ----------------------------------------
  // access spaces
  // ----------------------------------------
  typedef enum logic [1:0] {
    EBP_SP_PROG = 2'b00,
    EBP_SP_DATA = 2'b01,
    EBP_SP_IO   = 2'b10
  } ebp_space_e;
  // ----------------------------------------
  // pin driver states
  // ----------------------------------------
  typedef enum logic [1:0] {
    EBP_ST_FLOAT = 2'b00,
    EBP_ST_ADDR  = 2'b01,
    EBP_ST_WRITE = 2'b10
  } ebp_state_e;
endpackage : ebp_pkg

// >>> inc/ebp_keep_if.sv
// ebp_keep_if: signals between the bus controller and the data keeper
`timescale 1ns/1ps
interface ebp_keep_if;
  logic [15:0] pin_in;
  logic drive;
  logic enable;
  logic [15:0] hold_val;
  logic [15:0] hold_oe;
  modport ctrl (output pin_in, output drive, output enable, input hold_val, input hold_oe);
  modport keep (input pin_in, input drive, input enable, output hold_val, output hold_oe);
endinterface : ebp_keep_if

// >>> core/ebp_keeper.sv
// ebp_keeper: per-bit data bus keeper
`timescale 1ns/1ps
module ebp_keeper
  import ebp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // controller side
  ebp_keep_if.keep kif
);
  logic [15:0] last;
  genvar i;
  generate
    for (i = 0; i < EBP_DATA_W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          last[i] <= 1'b0;
        end else begin
          last[i] <= kif.pin_in[i];
        end
      end
      assign kif.hold_val[i] = last[i];
      assign kif.hold_oe[i] = kif.enable & ~kif.drive;
    end
  endgenerate
endmodule : ebp_keeper

// >>> core/ebp_bus_pins.sv
// ebp_bus_pins: address and data pin drivers with float control and keepers
`timescale 1ns/1ps
module ebp_bus_pins
  import ebp_pkg::*;
#(
  parameter int ADDR_W = EBP_ADDR_W,
  parameter int DATA_W = EBP_DATA_W
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // core access request
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [1:0] acc_space,
  input wire logic [19:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  output logic [15:0] acc_rdata,
  // control pins and bits
  input wire logic chip_reset_n,
  input wire logic hold_mode,
  input wire logic out_float_n,
  input wire logic keeper_enable_wr,
  input wire logic keeper_enable_val,
  output logic keeper_enable,
  // address pins
  output logic [19:0] ext_addr_o,
  output logic [19:0] ext_addr_oe,
  // data pins
  input wire logic [15:0] ext_data_i,
  output logic [15:0] ext_data_o,
  output logic [15:0] ext_data_oe
);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (ADDR_W != EBP_ADDR_W || DATA_W != EBP_DATA_W) begin : g_bad_width
    $error("ebp_bus_pins supports only 20 address and 16 data bits");
  end

  // ----------------------------------------
  // control pin synchronisers
  // ----------------------------------------
  logic [2:0] ctl_s1;
  logic [2:0] ctl_s2;
  wire [2:0] ctl_pin = {chip_reset_n, out_float_n, hold_mode};
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctl_s1 <= EBP_CTL_RST;
      ctl_s2 <= EBP_CTL_RST;
    end else begin
      ctl_s1 <= ctl_pin;
      ctl_s2 <= ctl_s1;
    end
  end
  wire rst_n_q = ctl_s2[EBP_CTL_RSTN_BIT];
  wire float_n_q = ctl_s2[EBP_CTL_FLOATN_BIT];
  wire hold_q = ctl_s2[EBP_CTL_HOLD_BIT];

  // ----------------------------------------
  // data pin synchroniser
  // ----------------------------------------
  logic [15:0] din_s1;
  logic [15:0] din_s2;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      din_s1 <= EBP_DATA_RST;
      din_s2 <= EBP_DATA_RST;
    end else begin
      din_s1 <= ext_data_i;
      din_s2 <= din_s1;
    end
  end

  // ----------------------------------------
  // float decode
  // ----------------------------------------
  wire hold_float = hold_q;
  wire off_float = ~float_n_q;
  wire rst_float = ~rst_n_q;
  wire addr_float = hold_float | off_float;
  wire data_float = addr_float | rst_float;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire is_prog = (acc_space == EBP_SP_PROG);
  wire [3:0] addr_hi = is_prog ? acc_addr[EBP_ADDR_W-1:EBP_LOW_W] : 4'h0;
  wire [15:0] addr_lo = acc_addr[EBP_LOW_W-1:0];
  wire [19:0] next_addr = {addr_hi, addr_lo};
  wire acc_go = acc_valid & ~data_float;

  // ----------------------------------------
  // driver state
  // ----------------------------------------
  ebp_state_e state;
  ebp_state_e next_state;
  always_comb begin
    next_state = EBP_ST_FLOAT;
    case ({acc_go, acc_write})
      2'b10: next_state = EBP_ST_ADDR;
      2'b11: next_state = EBP_ST_WRITE;
      default: next_state = EBP_ST_FLOAT;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= EBP_ST_FLOAT;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // address and write data registers
  // ----------------------------------------
  logic [19:0] addr_q;
  logic [15:0] wdata_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addr_q <= EBP_ADDR_RST;
    end else if (acc_valid) begin
      addr_q <= next_addr;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wdata_q <= EBP_DATA_RST;
    end else if (acc_valid) begin
      wdata_q <= acc_wdata;
    end
  end

  // ----------------------------------------
  // keeper enable bit
  // ----------------------------------------
  logic keep_q;
  wire keep_clr = sys_rst | ~rst_n_q;
  wire next_keep = keeper_enable_wr ? keeper_enable_val : keep_q;
  always_ff @(posedge clk_sys) begin
    if (keep_clr) begin
      keep_q <= EBP_KEEP_RST;
    end else begin
      keep_q <= next_keep;
    end
  end

  // ----------------------------------------
  // driver enables
  // ----------------------------------------
  logic addr_drv;
  logic data_drv;
  always_comb begin
    case (state)
      EBP_ST_FLOAT: begin
        addr_drv = 1'b0;
        data_drv = 1'b0;
      end
      EBP_ST_ADDR: begin
        addr_drv = 1'b1;
        data_drv = 1'b0;
      end
      EBP_ST_WRITE: begin
        addr_drv = 1'b1;
        data_drv = 1'b1;
      end
      default: begin
        addr_drv = 1'b0;
        data_drv = 1'b0;
      end
    endcase
  end
  wire addr_on = addr_drv & ~addr_float;
  wire data_on = data_drv & ~data_float;

  // ----------------------------------------
  // keeper
  // ----------------------------------------
  ebp_keep_if kif();
  assign kif.pin_in = din_s2;
  assign kif.drive = data_on;
  // keepers yield to every float condition
  assign kif.enable = keep_q & ~data_float;
  ebp_keeper u_keeper (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .kif(kif)
  );

  // ----------------------------------------
  // address pins
  // ----------------------------------------
  assign ext_addr_o = addr_q;
  assign ext_addr_oe = {20{addr_on}};

  // ----------------------------------------
  // data pins
  // ----------------------------------------
  genvar b;
  generate
    for (b = 0; b < EBP_DATA_W; b++) begin : g_dpin
      assign ext_data_o[b] = data_on ? wdata_q[b] : kif.hold_val[b];
      assign ext_data_oe[b] = data_on | kif.hold_oe[b];
    end
  endgenerate
  assign acc_rdata = din_s2;

  // ----------------------------------------
  // control bit readback
  // ----------------------------------------
  assign keeper_enable = keep_q;
endmodule : ebp_bus_pins

// >>> verification/ebp_bus_pins_properties.sv
// checker for ebp_bus_pins
`timescale 1ns/1ps
module ebp_bus_pins_properties (
  input wire logic clk_sys, sys_rst, acc_write, chip_reset_n, hold_mode, out_float_n,
  input wire logic keeper_enable_wr, keeper_enable_val, keeper_enable,
  input wire logic [1:0] acc_space,
  input wire logic [19:0] acc_addr, ext_addr_o, ext_addr_oe,
  input wire logic [15:0] acc_wdata, ext_data_o, ext_data_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire flt = hold_mode | ~out_float_n;
  wire drv = ext_addr_oe[0];
  chk_addr_low: assert property (drv |-> ext_addr_o[15:0] == $past(acc_addr[15:0]))
    else $error("addr low");
  chk_addr_high: assert property (drv |-> ext_addr_o[19:16] ==
    ($past(acc_space) == 2'h0 ? $past(acc_addr[19:16]) : 4'h0)) else $error("addr high");
  chk_addr_float: assert property (flt [*5] |-> ext_addr_oe == 20'h0)
    else $error("addr oe");
  chk_data_float: assert property ((flt | ~chip_reset_n) [*5] |-> ext_data_oe == 16'h0)
    else $error("data oe");
  chk_write_drive: assert property (chip_reset_n [*4] ##0 (drv && $past(acc_write)) |->
    ext_data_oe == 16'hffff && ext_data_o == $past(acc_wdata)) else $error("write");
  chk_data_quiet: assert property (!(drv && $past(acc_write)) && !keeper_enable &&
    !$past(keeper_enable) |-> ext_data_oe == 16'h0) else $error("quiet");
  chk_keep_reset: assert property ($past(sys_rst) |-> !keeper_enable)
    else $error("keep reset");
  chk_keep_load: assert property (chip_reset_n [*4] ##0 keeper_enable_wr |=>
    keeper_enable == $past(keeper_enable_val)) else $error("keep load");
  cover property (drv && $past(acc_write));
  cover property (keeper_enable && !drv && ext_data_oe == 16'hffff);
  cover property (flt [*5]);
endmodule : ebp_bus_pins_properties
bind ebp_bus_pins ebp_bus_pins_properties chk (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .acc_write(acc_write),
  .chip_reset_n(chip_reset_n),
  .hold_mode(hold_mode),
  .out_float_n(out_float_n),
  .keeper_enable_wr(keeper_enable_wr),
  .keeper_enable_val(keeper_enable_val),
  .keeper_enable(keeper_enable),
  .acc_space(acc_space),
  .acc_addr(acc_addr),
  .ext_addr_o(ext_addr_o),
  .ext_addr_oe(ext_addr_oe),
  .acc_wdata(acc_wdata),
  .ext_data_o(ext_data_o),
  .ext_data_oe(ext_data_oe)
);

// >>> verification/ebp_far_model.sv
// far-side memory model
`timescale 1ns/1ps
module ebp_far_model (
  input wire logic clk_sys,
  input wire logic [19:0] ext_addr_o, ext_addr_oe,
  input wire logic [15:0] ext_data_o, ext_data_oe,
  output logic [15:0] ext_data_i
);
  logic [15:0] last = 16'h0;
  wire [15:0] far = ext_addr_oe[0] ? ext_addr_o[15:0] ^ 16'h5a5a : ~last;
  assign ext_data_i = ext_data_oe & ext_data_o | ~ext_data_oe & far;
  always @(posedge clk_sys) last <= ext_data_i;
endmodule : ebp_far_model

// >>> verification/tb.sv
// bench for ebp_bus_pins
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0, sys_rst = 1'b1, acc_valid = 1'b0, acc_write = 1'b0, keeper_enable;
  logic chip_reset_n = 1'b1, hold_mode = 1'b0, out_float_n = 1'b1;
  logic keeper_enable_wr = 1'b0, keeper_enable_val = 1'b0;
  logic [1:0] acc_space = 2'h0;
  logic [19:0] acc_addr = 20'h0, ext_addr_o, ext_addr_oe;
  logic [15:0] acc_wdata = 16'h0, acc_rdata, ext_data_i, ext_data_o, ext_data_oe;
  int failures = 0, tests_run = 0;
  always #2 clk_sys = ~clk_sys;
  ebp_bus_pins dut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .acc_valid(acc_valid),
    .acc_write(acc_write),
    .acc_space(acc_space),
    .acc_addr(acc_addr),
    .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata),
    .chip_reset_n(chip_reset_n),
    .hold_mode(hold_mode),
    .out_float_n(out_float_n),
    .keeper_enable_wr(keeper_enable_wr),
    .keeper_enable_val(keeper_enable_val),
    .keeper_enable(keeper_enable),
    .ext_addr_o(ext_addr_o),
    .ext_addr_oe(ext_addr_oe),
    .ext_data_i(ext_data_i),
    .ext_data_o(ext_data_o),
    .ext_data_oe(ext_data_oe)
  );
  ebp_far_model mem (
    .clk_sys(clk_sys),
    .ext_addr_o(ext_addr_o),
    .ext_addr_oe(ext_addr_oe),
    .ext_data_o(ext_data_o),
    .ext_data_oe(ext_data_oe),
    .ext_data_i(ext_data_i)
  );
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic give_verdict;
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic t_acc(input logic [1:0] s, input logic w, input logic [19:0] a, input logic k);
    acc_valid = 1'b1;
    acc_write = w;
    acc_space = s;
    acc_addr = a;
    acc_wdata = a[15:0] ^ 16'h0ff0;
    cyc(1);
    chk("addr", s == 2'h0 ? a : a & 20'h0ffff, ext_addr_o);
    chk("aoe", 20'hfffff, ext_addr_oe);
    chk("doe", w ? 20'hffff : 20'h0, ext_data_oe);
    cyc(3);
    chk("dat", a[15:0] ^ (w ? 16'h0ff0 : 16'h5a5a), w ? ext_data_o : acc_rdata);
    acc_valid = 1'b0;
    cyc(2);
    chk("idle", k ? 20'hffff : 20'h0, ext_data_oe);
  endtask : t_acc
  task automatic t_keep(input logic v);
    keeper_enable_val = v;
    keeper_enable_wr = 1'b1;
    cyc(1);
    keeper_enable_wr = 1'b0;
    cyc(1);
    chk("kbit", v, keeper_enable);
    t_acc(2'h2, 1'b1, 20'h3c0f1, v);
    if (v) chk("kval", 20'h0cf01, ext_data_o);
  endtask : t_keep
  task automatic t_float;
    logic [19:0] g;
    acc_valid = 1'b1;
    for (int i = 0; i < 3; i++) begin
      out_float_n = i != 0;
      hold_mode = i == 1;
      chip_reset_n = i != 2;
      cyc(5);
      g = i == 2 ? {ext_data_oe, keeper_enable} : ext_addr_oe | ext_data_oe;
      chk("flt", 20'h0, g);
    end
    chip_reset_n = 1'b1;
    acc_valid = 1'b0;
  endtask : t_float
  initial begin
    cyc(16);
    chk("rst", 20'h0, {ext_data_oe, keeper_enable});
    sys_rst = 1'b0;
    cyc(3);
    for (int s = 0; s < 3; s++) begin
      t_acc(s[1:0], 1'b1, 20'hc3a5f, 1'b0);
      t_acc(s[1:0], 1'b0, 20'h5e71b, 1'b0);
    end
    t_keep(1'b1);
    t_keep(1'b0);
    t_keep(1'b1);
    t_float;
    give_verdict;
  end
  initial begin
    #20000;
    failures++;
    give_verdict;
  end
endmodule : tb
